// ===== inc/acp_defines.svh
`ifndef ACP_DEFINES_SVH
`define ACP_DEFINES_SVH

// register byte offsets
`define ACP_REG_CTRL 8'h00
`define ACP_REG_DEPTH 8'h04
`define ACP_REG_STATUS 8'h08
`define ACP_REG_OUT_SET 8'h0C
`define ACP_REG_IN_SEL 8'h10
`define ACP_REG_IN_DATA 8'h14
`define ACP_REG_IN_GAIN 8'h20
`define ACP_REG_IN_OFS 8'h40
`define ACP_REG_OUT_GAIN 8'h60
`define ACP_REG_OUT_OFS 8'h70
`define ACP_REG_OUT_CODE 8'h80

// field positions
`define ACP_CTRL_AUTO 0
`define ACP_CTRL_SAVE 1
`define ACP_CTRL_REBOOT 2
`define ACP_ST_BUSY 8
`define ACP_ST_VALID 9
`define ACP_OUT_CH_LSB 16
`define ACP_IN_VALID 31

// reset values and limits
`define ACP_DEPTH_RST 4'h1
`define ACP_MAX_DEPTH 9
`define ACP_OFS_MIN (-100)
`define ACP_OFS_MAX 100
`define ACP_GAIN_ONE 10000
`define ACP_CODE_MAX 4095

`endif

// ===== inc/acp_pkg.sv
package acp_pkg;

    typedef enum logic [1:0] {ACP_BOOT, ACP_IDLE, ACP_SUM, ACP_DONE} acp_state_e;

    typedef logic [11:0] acp_code_t;

endpackage : acp_pkg

// ===== hdl/acp_hist_mem.sv
module acp_hist_mem #(
    parameter int W = 12,
    parameter int DEPTH = 72,
    parameter int AW = 7
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_chk
        $error("acp_hist_mem: DEPTH does not fit AW");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [W-1:0] rdata;
    } acp_mem_s;

    acp_mem_s q, d;

    // one write port, one registered read port; a read of the word being
    // written returns the old word
    always_comb begin
        d = q;
        if (we && int'(waddr) < DEPTH) begin
            d.mem[waddr] = wdata;
        end
        d.rdata = (int'(raddr) < DEPTH) ? q.mem[raddr] : '0;
    end

    // storage carries no reset: history is qualified by the fill counts
    always_ff @(posedge clk) begin
        if (ce) begin
            q <= d;
        end
    end

    assign rdata = q.rdata;

endmodule : acp_hist_mem

// ===== hdl/acp_top.sv
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - four independent 12-bit unsigned output channels
// - set command carries channel and code
// - output code held until next command
// - default trims map 2048 to midscale
// - input gain trim scales by 1+x/10000
// - trims take effect only at boot; auto-reboot
// - input offset trim limited to -100..100
// - input read adds offset trim
// - output gain trim scales by 1+x/10000
// - output offset trim -100..100 added before converter
// - configurable moving-average depth for input reads
// - depth one returns latest sample
// - depth configurable from one to nine
// - per-channel history, newest replaces oldest, mean
// - input reads return 0..4095
////////////////////////////////////////////////////////////////////////////////
//
// The address map and the APB slave port were chosen for this implementation.
`include "acp_defines.svh"

module acp_top import acp_pkg::*; #(
    parameter int NUM_IN = 8,
    parameter int NUM_OUT = 4,
    parameter int HIST = `ACP_MAX_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_valid,
    input wire logic [2:0] adc_chan,
    input wire logic [11:0] adc_data,
    output logic [NUM_OUT*12-1:0] dac_codes,
    output logic dac_wr,
    output logic [1:0] dac_wr_chan
);
    localparam int MD = NUM_IN * HIST;
    localparam int MAW = $clog2(MD + 1);

    if (NUM_IN < 1 || NUM_IN > 8 || NUM_OUT < 1 || NUM_OUT > 4 || HIST < 1 || HIST > 15) begin : g_chk
        $error("acp_top: channel counts or history depth out of range");
    end

    typedef struct packed {
        acp_state_e state;
        logic auto_reboot;
        logic [3:0] depth_stg;
        logic [3:0] depth_act;
        logic [NUM_IN-1:0][15:0] in_gain_stg;
        logic [NUM_IN-1:0][15:0] in_gain_act;
        logic [NUM_IN-1:0][7:0] in_ofs_stg;
        logic [NUM_IN-1:0][7:0] in_ofs_act;
        logic [NUM_OUT-1:0][15:0] out_gain_stg;
        logic [NUM_OUT-1:0][15:0] out_gain_act;
        logic [NUM_OUT-1:0][7:0] out_ofs_stg;
        logic [NUM_OUT-1:0][7:0] out_ofs_act;
        logic [NUM_OUT-1:0][11:0] dac_code;
        logic dac_wr;
        logic [1:0] dac_chan;
        logic [NUM_IN-1:0][3:0] wr_ptr;
        logic [NUM_IN-1:0][3:0] fill;
        logic [2:0] sel;
        logic [3:0] n;
        logic [3:0] k;
        logic pend;
        logic [15:0] acc;
        logic [11:0] in_data;
        logic in_valid;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } acp_regs_s;

    acp_regs_s q, d;

    logic mem_we;
    logic [MAW-1:0] mem_waddr;
    logic [MAW-1:0] mem_raddr;
    logic [11:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // arithmetic helpers

    // v * (1 + g/10000) + o, clamped; shared by both paths so the order is fixed
    function automatic acp_code_t acp_trim(input acp_code_t v, input logic [15:0] g, input logic [7:0] o);
        logic signed [31:0] p;
        p = $signed({20'h00000, v}) * (32'sd`ACP_GAIN_ONE + 32'($signed(g)));
        p = p / 32'sd`ACP_GAIN_ONE + 32'($signed(o));
        if (p < 32'sd0) begin
            return 12'h000;
        end else if (p > 32'sd`ACP_CODE_MAX) begin
            return 12'hFFF;
        end
        return p[11:0];
    endfunction : acp_trim

    // trim offsets outside the documented span are refused, not clipped
    function automatic logic ofs_ok(input logic [31:0] w);
        return $signed(w) >= `ACP_OFS_MIN && $signed(w) <= `ACP_OFS_MAX;
    endfunction : ofs_ok

    // memory word of slot idx in the history ring of channel ch
    function automatic logic [MAW-1:0] hist_addr(input logic [2:0] ch, input logic [3:0] idx);
        return MAW'(int'(ch) * HIST + int'(idx));
    endfunction : hist_addr

    // slot holding the sample k steps back from the newest one
    function automatic logic [3:0] hist_back(input logic [3:0] ptr, input logic [3:0] k);
        int t;
        t = int'(ptr) + HIST - 1 - int'(k);
        if (t >= HIST) begin
            t = t - HIST;
        end
        return 4'(t);
    endfunction : hist_back

    // reciprocal scaled by 2^20, rounded up; 20 bits keep truncated means exact up to nine full-scale samples
    function automatic logic [20:0] recip(input logic [3:0] n);
        if (n == 4'h0) begin
            return 21'h00000;
        end
        return 21'((1048576 + int'(n) - 1) / int'(n));
    endfunction : recip

    function automatic logic [31:0] sext16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : sext16

    function automatic logic [31:0] sext8(input logic [7:0] v);
        return {{24{v[7]}}, v};
    endfunction : sext8

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic hit;
        logic bad;
        logic [31:0] rv;
        logic [36:0] prod;
        logic [2:0] ich;
        logic [1:0] och;
        logic [1:0] wch;
        hit = 1'b0;
        bad = 1'b0;
        rv = '0;
        prod = '0;
        ich = paddr[4:2];
        och = paddr[3:2];
        wch = pwdata[`ACP_OUT_CH_LSB +: 2];
        d = q;
        d.dac_wr = 1'b0;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        mem_we = 1'b0;
        mem_waddr = '0;
        mem_raddr = '0;

        // sample intake: write over the oldest slot of the channel's ring
        if (adc_valid && q.state != ACP_BOOT && int'(adc_chan) < NUM_IN) begin
            mem_we = 1'b1;
            mem_waddr = hist_addr(adc_chan, q.wr_ptr[adc_chan]);
            d.wr_ptr[adc_chan] = (int'(q.wr_ptr[adc_chan]) == HIST - 1) ? 4'h0 : q.wr_ptr[adc_chan] + 4'h1;
            if (int'(q.fill[adc_chan]) < HIST) begin
                d.fill[adc_chan] = q.fill[adc_chan] + 4'h1;
            end
        end

        // read engine; boot copies staged trims into the live path
        case (q.state)
            ACP_BOOT: begin
                d.depth_act = q.depth_stg;
                d.in_gain_act = q.in_gain_stg;
                d.in_ofs_act = q.in_ofs_stg;
                d.out_gain_act = q.out_gain_stg;
                d.out_ofs_act = q.out_ofs_stg;
                d.dac_code = '0;
                d.wr_ptr = '0;
                d.fill = '0;
                d.in_valid = 1'b0;
                d.state = ACP_IDLE;
            end
            ACP_SUM: begin
                d.pend = q.k < q.n;
                if (q.k < q.n) begin
                    mem_raddr = hist_addr(q.sel, hist_back(q.wr_ptr[q.sel], q.k));
                    d.k = q.k + 4'h1;
                end
                if (q.pend) begin
                    d.acc = q.acc + {4'h0, mem_rdata};
                end
                if (q.k >= q.n && !q.pend) begin
                    d.state = ACP_DONE;
                end
            end
            ACP_DONE: begin
                prod = q.acc * recip(q.n);
                d.in_data = acp_trim(prod[31:20], q.in_gain_act[q.sel], q.in_ofs_act[q.sel]);
                d.in_valid = 1'b1;
                d.state = ACP_IDLE;
            end
            default: begin
                d.state = ACP_IDLE;
            end
        endcase

        // register decode
        if (paddr == `ACP_REG_CTRL) begin
            hit = 1'b1;
            rv[`ACP_CTRL_AUTO] = q.auto_reboot;
        end else if (paddr == `ACP_REG_DEPTH) begin
            hit = 1'b1;
            rv[3:0] = q.depth_stg;
            bad = pwdata == 32'h0 || pwdata > 32'(HIST);
        end else if (paddr == `ACP_REG_STATUS) begin
            hit = 1'b1;
            rv[3:0] = q.depth_act;
            rv[`ACP_ST_BUSY] = q.state != ACP_IDLE;
            rv[`ACP_ST_VALID] = q.in_valid;
        end else if (paddr == `ACP_REG_OUT_SET) begin
            hit = 1'b1;
            bad = int'(wch) >= NUM_OUT || q.state == ACP_BOOT;
        end else if (paddr == `ACP_REG_IN_SEL) begin
            hit = 1'b1;
            rv[2:0] = q.sel;
            bad = pwdata >= 32'(NUM_IN) || q.state != ACP_IDLE;
        end else if (paddr == `ACP_REG_IN_DATA) begin
            hit = 1'b1;
            rv[`ACP_IN_VALID] = q.in_valid;
            rv[11:0] = q.in_data;
        end else if (paddr[7:5] == `ACP_REG_IN_GAIN >> 5 && paddr[1:0] == 2'h0 && int'(ich) < NUM_IN) begin
            hit = 1'b1;
            rv = sext16(q.in_gain_stg[ich]);
        end else if (paddr[7:5] == `ACP_REG_IN_OFS >> 5 && paddr[1:0] == 2'h0 && int'(ich) < NUM_IN) begin
            hit = 1'b1;
            rv = sext8(q.in_ofs_stg[ich]);
            bad = !ofs_ok(pwdata);
        end else if (paddr[7:4] == `ACP_REG_OUT_GAIN >> 4 && paddr[1:0] == 2'h0 && int'(och) < NUM_OUT) begin
            hit = 1'b1;
            rv = sext16(q.out_gain_stg[och]);
        end else if (paddr[7:4] == `ACP_REG_OUT_OFS >> 4 && paddr[1:0] == 2'h0 && int'(och) < NUM_OUT) begin
            hit = 1'b1;
            rv = sext8(q.out_ofs_stg[och]);
            bad = !ofs_ok(pwdata);
        end else if (paddr[7:4] == `ACP_REG_OUT_CODE >> 4 && paddr[1:0] == 2'h0 && int'(och) < NUM_OUT) begin
            hit = 1'b1;
            rv[11:0] = q.dac_code[och];
        end

        // first access cycle: answer is registered, so one wait state
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = (hit && !pwrite) ? rv : 32'h0;
            d.pslverr = !hit || (pwrite && bad);
        end

        // writes land at the edge where the master sees pready
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            if (paddr == `ACP_REG_CTRL) begin
                d.auto_reboot = pwdata[`ACP_CTRL_AUTO];
                if (pwdata[`ACP_CTRL_REBOOT] || (pwdata[`ACP_CTRL_SAVE] && pwdata[`ACP_CTRL_AUTO])) begin
                    d.state = ACP_BOOT;
                end
            end else if (paddr == `ACP_REG_DEPTH) begin
                d.depth_stg = pwdata[3:0];
            end else if (paddr == `ACP_REG_OUT_SET) begin
                // trims apply once per command; code then holds with no refresh
                d.dac_code[wch] = acp_trim(pwdata[11:0], q.out_gain_act[wch], q.out_ofs_act[wch]);
                d.dac_wr = 1'b1;
                d.dac_chan = wch;
            end else if (paddr == `ACP_REG_IN_SEL) begin
                d.sel = pwdata[2:0];
                d.n = (q.depth_act < q.fill[pwdata[2:0]]) ? q.depth_act : q.fill[pwdata[2:0]];
                d.k = 4'h0;
                d.acc = 16'h0000;
                d.pend = 1'b0;
                d.in_valid = 1'b0;
                d.state = ACP_SUM;
            end else if (paddr[7:5] == `ACP_REG_IN_GAIN >> 5) begin
                d.in_gain_stg[ich] = pwdata[15:0];
            end else if (paddr[7:5] == `ACP_REG_IN_OFS >> 5) begin
                d.in_ofs_stg[ich] = pwdata[7:0];
            end else if (paddr[7:4] == `ACP_REG_OUT_GAIN >> 4) begin
                d.out_gain_stg[och] = pwdata[15:0];
            end else if (paddr[7:4] == `ACP_REG_OUT_OFS >> 4) begin
                d.out_ofs_stg[och] = pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; reset lands in boot so zero trims go live

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.state <= ACP_BOOT;
            q.depth_stg <= `ACP_DEPTH_RST;
            q.depth_act <= `ACP_DEPTH_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample history

    acp_hist_mem #(
        .W(12),
        .DEPTH(MD),
        .AW(MAW)
    ) u_hist (
        .clk(pclk),
        .ce(ce),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(adc_data),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign dac_codes = q.dac_code;
    assign dac_wr = q.dac_wr;
    assign dac_wr_chan = q.dac_chan;

endmodule : acp_top

// ===== test/acp_monitor.sv
module acp_monitor import acp_pkg::*; #(
    parameter int NUM_OUT = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_OUT*12-1:0] dac_codes,
    input wire logic dac_wr,
    input wire logic [1:0] dac_wr_chan
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // completed writes; a refused one must have no effect
    logic wr_rdy;
    logic acc;
    logic ctrl_wr;
    logic [NUM_OUT*12-1:0] lane;
    assign wr_rdy = psel && penable && pready && pwrite;
    assign acc = wr_rdy && !pslverr;
    assign ctrl_wr = acc && paddr == 8'h00;
    assign lane = {{(NUM_OUT*12-12){1'b0}}, 12'hFFF} << (12 * dac_wr_chan);
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_access;
        psel && penable && ce;
    endsequence
    ////////////////////////////////////////////////////////////////
    setup_wait_a: assert property (s_setup ##1 s_access |=> pready)
        else $error("no answer after one wait state");
    set_cmd_a: assert property (acc && paddr == 8'h0C |=> dac_wr && dac_wr_chan == $past(pwdata[17:16]))
        else $error("set command did not reach its channel");
    chan_iso_a: assert property (dac_wr |-> ((dac_codes ^ $past(dac_codes)) & ~lane) == '0)
        else $error("write disturbed another channel");
    hold_code_a: assert property (!dac_wr && !$past(ctrl_wr) && !$past(ctrl_wr, 2) && !$past(ctrl_wr, 3)
        |-> $stable(dac_codes)) else $error("output code changed without command");
    reboot_clr_a: assert property (ctrl_wr && (pwdata[2] || pwdata[1:0] == 2'h3) |-> ##[1:3] dac_codes == '0)
        else $error("reboot did not restart outputs");
    dep_refuse_a: assert property (wr_rdy && paddr == 8'h04 && (pwdata == 32'h0 || pwdata > 32'h9) |-> pslverr)
        else $error("bad depth accepted");
    ofs_refuse_a: assert property (wr_rdy && (paddr[7:5] == 3'h2 || paddr[7:4] == 4'h7)
        && ($signed(pwdata) > 100 || $signed(pwdata) < -100) |-> pslverr) else $error("bad offset accepted");
    rd_range_a: assert property (psel && penable && pready && !pwrite && paddr == 8'h14 |-> prdata[30:12] == '0)
        else $error("reading beyond twelve bits");
endmodule : acp_monitor

bind acp_top acp_monitor #(.NUM_OUT(NUM_OUT)) u_mon (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dac_codes, .dac_wr, .dac_wr_chan);

// ===== test/acp_conv_model.sv
module acp_conv_model import acp_pkg::*; #(
    parameter int NUM_OUT = 4
) (
    input wire logic pclk,
    input wire logic [NUM_OUT*12-1:0] dac_codes,
    input wire logic dac_wr,
    input wire logic [1:0] dac_wr_chan,
    output logic adc_valid,
    output logic [2:0] adc_chan,
    output logic [11:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    acp_code_t dac_out [NUM_OUT];
    initial begin
        adc_valid = 1'b0;
        adc_chan = 3'h0;
        adc_data = 12'h0;
    end
    // the converter only latches a code on the write strobe
    always @(posedge pclk) begin
        if (dac_wr) begin
            dac_out[dac_wr_chan] <= dac_codes[12*dac_wr_chan +: 12];
        end
    end
    // one conversion after a chosen delay; lines show garbage once released
    task automatic sample(input logic [2:0] ch, input acp_code_t d, input int gap);
        repeat (gap + 1) @(posedge pclk);
        adc_valid <= 1'b1;
        adc_chan <= ch;
        adc_data <= d;
        @(posedge pclk);
        adc_valid <= 1'b0;
        adc_chan <= ~ch;
        adc_data <= ~d;
    endtask : sample
endmodule : acp_conv_model

// ===== test/tb_top.sv
module tb_top import acp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_valid, dac_wr, er, ce;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] adc_chan;
    logic [11:0] adc_data;
    logic [47:0] dac_codes;
    logic [1:0] dac_wr_chan;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int gi [8], oi [8], go [4], oo [4], cv [4];
    int dep, c, ch, s, d;
    logic [7:0] ba [6] = '{8'h04, 8'h04, 8'h40, 8'h5C, 8'h70, 8'h18};
    logic [31:0] bd [6] = '{32'h0, 32'hA, 32'h65, 32'hFFFFFF9B, 32'h65, 32'h1};
    acp_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data), .dac_codes(dac_codes),
        .dac_wr(dac_wr), .dac_wr_chan(dac_wr_chan));
    acp_conv_model conv (.pclk(pclk), .dac_codes(dac_codes), .dac_wr(dac_wr), .dac_wr_chan(dac_wr_chan),
        .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data));
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // a hang is cut short well past the expected few hundred cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one transfer, then an idle edge so psel is never driven twice in a step;
    // the wait has no limit of its own, a hang runs into the cycle ceiling
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic poll(input logic [7:0] a, input int b, input logic lvl);
        do begin
            apb(1'b0, a, 32'h0);
        end while (rd[b] !== lvl);
    endtask : poll
    function automatic int cal(int v, int g, int o);
        int r = v * (10000 + g) / 10000 + o;
        return r < 0 ? 0 : (r > 4095 ? 4095 : r);
    endfunction : cal
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        void'($urandom(40993));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, 8'h08, 32'h0);
        check(rd & 32'hF, 32'h1);
        // default trims pass codes through, corners included
        for (int j = 0; j < 4; j++) begin
            cv[j] = j == 0 ? 2048 : (j == 1 ? 4095 : (j == 2 ? 0 : $urandom_range(4095)));
            apb(1'b1, 8'h0C, (j << 16) | cv[j]);
            apb(1'b0, 8'(8'h80 + 4 * j), 32'h0);
            check(rd, cv[j]);
            check(conv.dac_out[j], cv[j]);
        end
        for (int j = 0; j < 4; j++) check(32'(dac_codes[12 * j +: 12]), cv[j]);
        conv.sample(3'h5, 12'h123, 0);
        conv.sample(3'h5, 12'h800, 2);
        apb(1'b1, 8'h10, 32'h5);
        poll(8'h14, 31, 1'b1);
        check(rd, 32'h80000800);
        apb(1'b1, 8'h00, 32'h4);
        repeat (3) @(posedge pclk);
        poll(8'h08, 8, 1'b0);
        apb(1'b0, 8'h84, 32'h0);
        check(rd, 32'h0);
        // illegal values are refused and leave nothing behind
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ba[i], bd[i]);
            check(er, 1'b1);
        end
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h1);
        // stage random trims; they must not act before a reboot
        dep = $urandom_range(9, 2);
        apb(1'b1, 8'h04, dep);
        for (int i = 0; i < 8; i++) begin
            gi[i] = $urandom_range(1000) - 500;
            oi[i] = i == 0 ? -100 : $urandom_range(200) - 100;
            apb(1'b1, 8'(8'h20 + 4 * i), gi[i]);
            apb(1'b1, 8'(8'h40 + 4 * i), oi[i]);
            check(er, 1'b0);
            if (i < 4) begin
                go[i] = $urandom_range(1000) - 500;
                oo[i] = i == 0 ? 100 : (i == 2 ? -100 : 0);
                apb(1'b1, 8'(8'h60 + 4 * i), go[i]);
                apb(1'b1, 8'(8'h70 + 4 * i), oo[i]);
            end
        end
        apb(1'b1, 8'h0C, 32'h303E8);
        apb(1'b0, 8'h8C, 32'h0);
        check(rd, 32'h3E8);
        apb(1'b1, 8'h00, 32'h3);
        repeat (3) @(posedge pclk);
        poll(8'h08, 8, 1'b0);
        check(rd & 32'hF, dep);
        // averaged, trimmed readings; the last pass is full scale
        for (int k = 0; k < 3; k++) begin
            ch = $urandom_range(7);
            s = 0;
            for (int i = 0; i < dep + 2; i++) begin
                d = k == 2 ? 4095 : $urandom_range(4095);
                conv.sample(ch[2:0], d[11:0], $urandom_range(3));
                if (i >= 2) s += d;
            end
            // a sample offered while the block is frozen must be lost
            ce <= 1'b0;
            conv.sample(ch[2:0], 12'(k * 1000 + 7), 0);
            ce <= 1'b1;
            apb(1'b1, 8'h10, ch);
            poll(8'h14, 31, 1'b1);
            check(rd, 32'h80000000 | cal(s / dep, gi[ch], oi[ch]));
        end
        // trimmed outputs, with saturation at zero and, only for a positive random gain, at full scale
        for (int j = 0; j < 4; j++) begin
            c = j == 1 ? 4095 : (j == 2 ? 0 : $urandom_range(4095));
            apb(1'b1, 8'h0C, (j << 16) | c);
            apb(1'b0, 8'(8'h80 + 4 * j), 32'h0);
            check(rd, cal(c, go[j], oo[j]));
            check(conv.dac_out[j], cal(c, go[j], oo[j]));
        end
        // save without the auto bit must not reboot: the last code survives
        apb(1'b1, 8'h00, 32'h2);
        repeat (3) @(posedge pclk);
        apb(1'b0, 8'h8C, 32'h0);
        check(rd, cal(c, go[3], oo[3]));
        final_report();
    end
endmodule : tb_top
